// File: test/dram_bank_ctl_checker.sv
// assertions on the dram command-side block ports
`timescale 1ns/1ps
module dram_bank_ctl_checker (
    input wire logic        clk,          // clock
    input wire logic        reset,        // sync reset
    input wire logic        cs_n,         // chip select
    input wire logic        act_n,        // activate strobe
    input wire logic        ras_n,        // ras
    input wire logic        cas_n,        // cas
    input wire logic        we_n,         // we
    input wire logic        cke,          // clock enable
    input wire logic [1:0]  bg,           // bank group
    input wire logic [1:0]  ba,           // bank address
    input wire logic [17:0] addr,         // address
    input wire logic [15:0] bank_open,    // open banks
    input wire logic [15:0] bank_busy,    // precharging banks
    input wire logic        in_self_ref,  // self-refresh
    input wire logic        odt_off,      // termination off
    input wire logic        dll_off,      // dll off
    input wire logic        dll_rst,      // dll reset pulse
    input wire logic        ref_busy,     // refresh running
    input wire logic [17:0] ref_row,      // refresh counter
    input wire logic        cmd_blocked,  // wait active
    input wire logic        viol          // sticky violation
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    logic [3:0] bk;
    logic       go;
    logic       idle;
    logic       pre;
    logic       ref_c;
    assign bk = {bg, ba};
    // only commands outside every wait are taken
    assign go = !cs_n && cke && !cmd_blocked && !in_self_ref && !ref_busy;
    assign idle = (bank_open == 16'h0) && (bank_busy == 16'h0);
    assign pre = go && act_n && !ras_n && cas_n && !we_n;
    assign ref_c = go && act_n && !ras_n && !cas_n && we_n && idle;
    act_opens_a:
    assert property (go && !act_n && !bank_open[bk] && !bank_busy[bk]
        |=> bank_open[$past(bk)]) else $error("activate left bank shut");
    pre_closes_a:
    assert property (pre && !addr[10] |=> !bank_open[$past(bk)])
        else $error("precharge left bank open");
    prea_closes_a:
    assert property (pre && addr[10] |=> bank_open == 16'h0)
        else $error("precharge all left a bank open");
    ref_step_a:
    assert property (ref_c |=> ref_row == $past(ref_row) + 18'h1)
        else $error("refresh counter did not step");
    rfc_block_a:
    assert property (ref_c |-> ##3 cmd_blocked [*8])
        else $error("refresh wait ended early");
    sr_levels_a:
    assert property (odt_off == in_self_ref && dll_off == in_self_ref)
        else $error("termination or dll out of step");
    sr_exit_a:
    assert property (in_self_ref && $rose(cke) |-> ##[1:3] !in_self_ref)
        else $error("self-refresh not left");
    dll_exit_a:
    assert property (in_self_ref && $rose(cke) |-> ##[1:3] dll_rst)
        else $error("no dll reset on exit");
    dll_pulse_a:
    assert property (dll_rst |=> !dll_rst) else $error("dll reset too long");
    viol_sticky_a:
    assert property (viol |=> viol) else $error("violation flag cleared");
    cover property (go && !act_n);
    cover property (ref_c);
    cover property ($rose(in_self_ref));
    cover property (dll_rst);
endmodule : dram_bank_ctl_checker
bind dram_bank_ctl dram_bank_ctl_checker chk_u (.clk(clk), .reset(reset),
    .cs_n(cs_n), .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .cke(cke), .bg(bg), .ba(ba), .addr(addr), .bank_open(bank_open),
    .bank_busy(bank_busy), .in_self_ref(in_self_ref), .odt_off(odt_off),
    .dll_off(dll_off), .dll_rst(dll_rst), .ref_busy(ref_busy),
    .ref_row(ref_row), .cmd_blocked(cmd_blocked), .viol(viol));

// File: test/dram_bank_ctl_test.sv
// self-checking bench for the dram command-side block
`timescale 1ns/1ps
module dram_bank_ctl_test;
    import dram_ctl_pkg::*;
    logic        clk, reset, sr_abort_en, rd_stb, dll_seen;
    logic        cs_n, act_n, ras_n, cas_n, we_n, cke;
    logic [1:0]  bg, ba;
    logic [17:0] addr, ref_row, r0;
    logic [3:0]  rd_addr;
    logic [31:0] rd_data, d;
    logic [15:0] bank_open, bank_busy;
    logic        in_self_ref, odt_off, dll_off, dll_rst, ref_busy;
    logic        cmd_blocked, viol;
    int          err_total, checks_done, cyc;
    memctl_model ctl_u (.clk(clk), .cs_n(cs_n), .act_n(act_n),
        .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n), .cke(cke), .bg(bg),
        .ba(ba), .addr(addr));
    dram_bank_ctl dut_u (.clk(clk), .reset(reset), .cs_n(cs_n),
        .act_n(act_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
        .cke(cke), .bg(bg), .ba(ba), .addr(addr),
        .sr_abort_en(sr_abort_en), .rd_addr(rd_addr), .rd_stb(rd_stb),
        .rd_data(rd_data), .bank_open(bank_open), .bank_busy(bank_busy),
        .in_self_ref(in_self_ref), .odt_off(odt_off), .dll_off(dll_off),
        .dll_rst(dll_rst), .ref_busy(ref_busy), .ref_row(ref_row),
        .cmd_blocked(cmd_blocked), .viol(viol));
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : final_report
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // status appears only in the cycle after the strobe
    task automatic rd_status(output logic [31:0] v);
        @(posedge clk);
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        #1 v = rd_data;
    endtask : rd_status
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (dll_rst === 1'b1) dll_seen <= 1'b1;
        if (cyc == 3000) begin
            err_total++;
            final_report();
        end
    end
    initial begin
        {reset, sr_abort_en, rd_stb, dll_seen, rd_addr} = 8'h80;
        {err_total, checks_done, cyc} = 0;
        repeat (20) @(posedge clk);
        reset <= 1'b0;
        rd_status(d);
        check("status at reset", d, 32'h0);
        for (int i = 0; i < 16; i++) begin
            ctl_u.issue(CMD_ACT, i[3:0], {i[3:0], 14'h15a5});
        end
        step(2);
        check("all open", {16'h0, bank_open}, 32'hffff);
        @(posedge clk) rd_addr <= 4'h9;
        step(2);
        check("row of bank 9", rd_data, 32'h000255a5);
        ctl_u.issue(CMD_PRE, 4'h9, 18'h0);
        step(2);
        check("bank 9 shut", {16'h0, bank_open}, 32'hfdff);
        ctl_u.issue(CMD_PRE, 4'h9, 18'h0);
        step(2);
        check("idle precharge", {31'h0, viol}, 32'h0);
        ctl_u.issue(CMD_PREA, 4'h0, 18'h400);
        step(3);
        check("all shut", {bank_busy, bank_open}, 32'h0);
        r0 = ref_row;
        ctl_u.issue(CMD_REF, 4'h0, 18'h3ffff);
        step(3);
        check("refresh row", {14'h0, ref_row}, {14'h0, r0 + 18'h1});
        check("trfc wait", {31'h0, cmd_blocked}, 32'h1);
        step(16);
        check("trfc over", {15'h0, cmd_blocked, bank_open}, 32'h0);
        r0 = ref_row;
        ctl_u.issue(CMD_SRE, 4'h0, 18'h0);
        step(4);
        check("sr levels", {in_self_ref, odt_off, dll_off}, 32'h7);
        check("sr first ref", {14'h0, ref_row}, {14'h0, r0 + 18'h1});
        ctl_u.issue(CMD_ACT, 4'h2, 18'h0);
        step(2);
        check("pins ignored", {16'h0, bank_open}, 32'h0);
        step(312);
        check("sr timer ref", {14'h0, ref_row}, {14'h0, r0 + 18'h2});
        ctl_u.set_cke(1'b1);
        step(3);
        check("sr exit", {dll_seen, in_self_ref, odt_off, dll_off}, 32'h8);
        check("txs wait", {31'h0, cmd_blocked}, 32'h1);
        step(15);
        check("txs over", {31'h0, cmd_blocked}, 32'h0);
        ctl_u.issue(CMD_REF, 4'h0, 18'h0);
        step(18);
        @(posedge clk) sr_abort_en <= 1'b1;
        ctl_u.issue(CMD_SRE, 4'h0, 18'h0);
        step(6);
        ctl_u.set_cke(1'b1);
        step(5);
        check("abort wait", {30'h0, in_self_ref, cmd_blocked}, 32'h0);
        ctl_u.issue(CMD_SRE, 4'h0, 18'h0);
        step(3);
        check("re-entry refused", {in_self_ref, viol}, 32'h1);
        ctl_u.set_cke(1'b1);
        rd_status(d);
        check("final status", d, 32'h000c0000);
        final_report();
    end
endmodule : dram_bank_ctl_test

// File: test/memctl_model.sv
// command-side controller model driving the dram pins
`timescale 1ns/1ps
module memctl_model
    import dram_ctl_pkg::*;
(
    input  wire logic        clk,    // bench clock
    output logic             cs_n,   // chip select
    output logic             act_n,  // activate strobe
    output logic             ras_n,  // ras / a16
    output logic             cas_n,  // cas / a15
    output logic             we_n,   // we / a14
    output logic             cke,    // clock enable
    output logic [1:0]       bg,     // bank group
    output logic [1:0]       ba,     // bank address
    output logic [17:0]      addr    // row address
);
    initial begin
        {cs_n, act_n, ras_n, cas_n, we_n, cke} = 6'h3f;
        {bg, ba, addr} = 22'h0;
    end
    task automatic issue(input cmd_e c, input logic [3:0] b,
                         input logic [17:0] r);
        @(posedge clk);
        cs_n <= 1'b0;
        {bg, ba} <= b;
        addr <= r;
        case (c)
            CMD_ACT: {act_n, ras_n, cas_n, we_n} <= {1'b0, r[16:14]};
            CMD_PRE, CMD_PREA: {act_n, ras_n, cas_n, we_n} <= 4'b1010;
            CMD_REF: {act_n, ras_n, cas_n, we_n} <= 4'b1001;
            CMD_SRE: begin
                {act_n, ras_n, cas_n, we_n} <= 4'b1001;
                cke <= 1'b0;
            end
            default: {act_n, ras_n, cas_n, we_n} <= 4'b1101;
        endcase
        @(posedge clk);
        cs_n <= 1'b1;
        // released address flips so a stale value never looks valid
        addr <= ~r;
    endtask : issue
    // no mode writes or reads ever sent
    // exit is cke rising under deselect
    task automatic set_cke(input logic v);
        @(posedge clk);
        cke <= v;
    endtask : set_cke
endmodule : memctl_model

// File: verilog/cmd_decode.sv
// decoder of control pins into one command
`timescale 1ns/1ps
`include "dram_ctl_defs.svh"
module cmd_decode
    import dram_ctl_pkg::*;
(
    input  wire logic        cs_n,     // chip select
    input  wire logic        act_n,    // activate strobe
    input  wire logic        ras_n,    // ras / a16
    input  wire logic        cas_n,    // cas / a15
    input  wire logic        we_n,     // we / a14
    input  wire logic        cke,      // clock enable
    input  wire logic        a10,      // all-bank select
    input  wire logic [1:0]  bg,       // bank group
    input  wire logic [1:0]  ba,       // bank address
    input  wire logic [17:0] addr,     // row address
    cmd_if.src               dec       // decoded command
);
    always_comb begin
        dec.cmd  = CMD_NOP;
        dec.bank = {bg, ba};
        dec.row  = addr;
        if (!cs_n) begin
            if (!act_n) begin
                dec.cmd = CMD_ACT;
            end else if (!ras_n && cas_n && !we_n) begin
                dec.cmd = a10 ? CMD_PREA : CMD_PRE;
            end else if (!ras_n && !cas_n && we_n) begin
                dec.cmd = cke ? CMD_REF : CMD_SRE;
            end else if (ras_n && !cas_n) begin
                dec.cmd = CMD_RW;
            end
        end
    end
endmodule : cmd_decode

// File: verilog/cmd_if.sv
// decoded command carried from decoder to controller
`timescale 1ns/1ps
interface cmd_if;
    import dram_ctl_pkg::*;
    cmd_e       cmd;
    logic [3:0] bank;
    logic [17:0] row;
    modport src (output cmd, output bank, output row);
    modport dst (input cmd, input bank, input row);
endinterface : cmd_if

// File: verilog/dram_bank_ctl.sv
// bank state, refresh and self-refresh control of the dram
//
// The placing of the registers and strobed register access were decided locally.
`timescale 1ns/1ps
`include "dram_ctl_defs.svh"
module dram_bank_ctl
    import dram_ctl_pkg::*;
(
    input  wire logic        clk,          // 40 mhz clock
    input  wire logic        reset,        // sync reset, active high
    input  wire logic        cs_n,         // chip select
    input  wire logic        act_n,        // activate strobe
    input  wire logic        ras_n,        // ras / a16
    input  wire logic        cas_n,        // cas / a15
    input  wire logic        we_n,         // we / a14
    input  wire logic        cke,          // clock enable
    input  wire logic [1:0]  bg,           // bank group
    input  wire logic [1:0]  ba,           // bank address
    input  wire logic [17:0] addr,         // address, a10 selects all
    input  wire logic        sr_abort_en,  // self-refresh abort enable
    input  wire logic [3:0]  rd_addr,      // register read address
    input  wire logic        rd_stb,       // register read strobe
    output logic [31:0]      rd_data,      // register read data
    output logic [15:0]      bank_open,    // per-bank open row
    output logic [15:0]      bank_busy,    // per-bank precharge timing
    output logic             in_self_ref,  // self-refresh residency
    output logic             odt_off,      // termination forced hi-z
    output logic             dll_off,      // dll disabled
    output logic             dll_rst,      // dll reset pulse on exit
    output logic             ref_busy,     // refresh cycle running
    output logic [17:0]      ref_row,      // internal refresh row
    output logic             cmd_blocked,  // exit or refresh wait active
    output logic             viol          // sticky illegal command
);
    localparam logic [8:0] TRP  = 9'(`T_RP_CYC);
    localparam logic [8:0] TRFC = 9'(`T_RFC_CYC);
    localparam logic [8:0] TXS  = 9'(`T_XS_CYC);
    localparam logic [8:0] TXSA = 9'(`T_XSA_CYC);
    localparam logic [18:0] TSRREF = 19'(`T_SRREF_CYC);

    cmd_if dec ();

    cmd_decode u_dec (
        .cs_n  (cs_n),
        .act_n (act_n),
        .ras_n (ras_n),
        .cas_n (cas_n),
        .we_n  (we_n),
        .cke   (cke),
        .a10   (addr[10]),
        .bg    (bg),
        .ba    (ba),
        .addr  (addr),
        .dec   (dec)
    );

    mode_e        mode_r;
    logic [8:0]   wait_r;
    logic [18:0]  srt_r;
    logic         sr_ref_pend_r;
    logic         need_ref_r;
    logic [17:0]  open_row_r [16];
    logic [8:0]   prt_r [16];
    logic         bad;
    logic         all_idle;
    logic         cmd_live;

    // control pins count only in normal mode with cke high, except self-refresh entry, which is taken with cke low
    assign cmd_live = (mode_r == ST_NORM) && cke;

    always_comb begin
        all_idle = 1'b1;
        for (int i = 0; i < 16; i++) begin
            if (bank_open[i] || prt_r[i] != 9'h000) begin
                all_idle = 1'b0;
            end
        end
    end

    // per-bank open state and trp timers
    for (genvar b = 0; b < 16; b++) begin : g_bank
        logic hit;
        assign hit = dec.bank == 4'(b);
        always_ff @(posedge clk) begin
            if (reset) begin
                bank_open[b]  <= 1'b0;
                bank_busy[b]  <= 1'b0;
                prt_r[b]      <= 9'h000;
                open_row_r[b] <= 18'h00000;
            end else if (cmd_live && dec.cmd == CMD_ACT && hit
                         && !bank_open[b] && prt_r[b] == 9'h000) begin
                bank_open[b]  <= 1'b1;
                open_row_r[b] <= dec.row;
            end else if (cmd_live && ((dec.cmd == CMD_PRE && hit)
                         || dec.cmd == CMD_PREA)) begin
                bank_open[b] <= 1'b0;
                prt_r[b]     <= TRP;
                bank_busy[b] <= TRP != 9'h000;
            end else if (prt_r[b] != 9'h000) begin
                // bank idle after trp
                // busy mirrors a running timer so act refusals match it
                prt_r[b]     <= prt_r[b] - 9'h001;
                bank_busy[b] <= prt_r[b] != 9'h001;
            end
        end
    end

    // command legality against bank state
    always_comb begin
        bad = 1'b0;
        if (cke && !cs_n && mode_r != ST_NORM && mode_r != ST_SR) begin
            // only deselect during trfc or txs
            bad = 1'b1;
        end else if (mode_r == ST_NORM && !cke && !cs_n
                     && dec.cmd == CMD_SRE) begin
            // entry refused while a refresh is owed
            bad = !all_idle || need_ref_r;
        end else if (cmd_live) begin
            unique case (dec.cmd)
                // act to open or precharging bank
                CMD_ACT: bad = bank_open[dec.bank]
                               || prt_r[dec.bank] != 9'h000;
                CMD_RW:  bad = !bank_open[dec.bank];
                // banks idle before refresh or entry
                CMD_REF: bad = !all_idle;
                CMD_SRE: bad = !all_idle || need_ref_r;
                CMD_PRE, CMD_PREA, CMD_NOP: bad = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            viol <= 1'b0;
        end else if (bad) begin
            viol <= 1'b1;
        end
    end

    // mode sequencing: refresh, self-refresh, exit wait
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_r <= ST_NORM;
            wait_r <= 9'h000;
        end else begin
            unique case (mode_r)
                ST_NORM: begin
                    if (cmd_live && dec.cmd == CMD_REF && all_idle) begin
                        mode_r <= ST_REF;
                        wait_r <= TRFC;
                    end else if (!cke && !cs_n && dec.cmd == CMD_SRE
                                 && all_idle && !need_ref_r) begin
                        mode_r <= ST_SR;
                    end
                end
                ST_REF: begin
                    if (wait_r <= 9'h001) begin
                        mode_r <= ST_NORM;
                        wait_r <= 9'h000;
                    end else begin
                        wait_r <= wait_r - 9'h001;
                    end
                end
                ST_SR: begin
                    if (cke) begin
                        mode_r <= ST_XS;
                        wait_r <= sr_abort_en ? TXSA : TXS;
                    end
                end
                ST_XS: begin
                    if (wait_r <= 9'h001) begin
                        mode_r <= ST_NORM;
                        wait_r <= 9'h000;
                    end else begin
                        wait_r <= wait_r - 9'h001;
                    end
                end
            endcase
        end
    end

    // extra refresh owed after each exit
    always_ff @(posedge clk) begin
        if (reset) begin
            need_ref_r <= 1'b0;
        end else if (mode_r == ST_SR && cke) begin
            need_ref_r <= 1'b1;
        end else if (mode_r == ST_REF) begin
            need_ref_r <= 1'b0;
        end
    end

    // first internal refresh at once, then timer
    always_ff @(posedge clk) begin
        if (reset) begin
            srt_r         <= 19'h00000;
            sr_ref_pend_r <= 1'b0;
        end else if (mode_r != ST_SR) begin
            srt_r         <= 19'h00000;
            sr_ref_pend_r <= mode_r == ST_NORM && !cke && !cs_n
                             && dec.cmd == CMD_SRE && all_idle
                             && !need_ref_r;
        end else if (srt_r >= TSRREF - 19'h00001) begin
            srt_r         <= 19'h00000;
            sr_ref_pend_r <= 1'b1;
        end else begin
            srt_r         <= srt_r + 19'h00001;
            sr_ref_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ref_row <= 18'h00000;
        end else if ((mode_r == ST_NORM && cmd_live
                      && dec.cmd == CMD_REF && all_idle)
                     || sr_ref_pend_r) begin
            ref_row <= ref_row + 18'h00001;
        end else if (mode_r == ST_SR && cke && sr_abort_en
                     && srt_r == 19'h00000 && !sr_ref_pend_r) begin
            ref_row <= ref_row - 18'h00001;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            in_self_ref <= 1'b0;
            odt_off     <= 1'b0;
            dll_off     <= 1'b0;
            dll_rst     <= 1'b0;
        end else begin
            in_self_ref <= mode_r == ST_SR && !cke;
            odt_off     <= mode_r == ST_SR && !cke;
            dll_off     <= mode_r == ST_SR && !cke;
            dll_rst     <= mode_r == ST_SR && cke;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            ref_busy    <= 1'b0;
            cmd_blocked <= 1'b0;
        end else begin
            ref_busy    <= mode_r == ST_REF || sr_ref_pend_r;
            cmd_blocked <= mode_r == ST_REF || mode_r == ST_XS;
        end
    end

    // status readout: strobe selects state, otherwise open row of bank rd_addr 0..15
    always_ff @(posedge clk) begin
        if (reset) begin
            rd_data <= 32'h00000000;
        end else if (rd_stb) begin
            rd_data <= {12'h000, need_ref_r, viol, mode_r, bank_open};
        end else begin
            rd_data <= {14'h0000, open_row_r[rd_addr]};
        end
    end
endmodule : dram_bank_ctl

// File: verilog/dram_ctl_defs.svh
// timing counts and field widths for the dram command-side block
`ifndef DRAM_CTL_DEFS_SVH
`define DRAM_CTL_DEFS_SVH
`define CLK_PERIOD_PS   25000
`define T_RP_PS         13750
`define T_RP_CYC        (((`T_RP_PS) + (`CLK_PERIOD_PS) - 1) / (`CLK_PERIOD_PS))
`define T_RFC_PS        350000
`define T_RFC_CYC       (((`T_RFC_PS) + (`CLK_PERIOD_PS) - 1) / (`CLK_PERIOD_PS))
`define T_XS_EXTRA_PS   10000
`define T_XS_CYC        (((`T_RFC_PS) + (`T_XS_EXTRA_PS) + (`CLK_PERIOD_PS) - 1) / (`CLK_PERIOD_PS))
`define T_XSA_PS        50000
`define T_XSA_CYC       (((`T_XSA_PS) + (`CLK_PERIOD_PS) - 1) / (`CLK_PERIOD_PS))
`define T_CKE_PS        5000
`define T_CKE_CYC       1
`define T_SRREF_PS      7800000
`define T_SRREF_CYC     ((`T_SRREF_PS) / (`CLK_PERIOD_PS))
`define TMR_W           9
`define NBANK           16
`define ROW_W           18
`endif

// File: verilog/dram_ctl_pkg.sv
// types shared by the dram command-side block
package dram_ctl_pkg;
    typedef enum logic [2:0] {
        CMD_NOP = 3'b000,
        CMD_ACT = 3'b001,
        CMD_PRE = 3'b010,
        CMD_PREA = 3'b011,
        CMD_REF = 3'b100,
        CMD_SRE = 3'b101,
        CMD_RW = 3'b110
    } cmd_e;
    typedef enum logic [1:0] {
        ST_NORM = 2'b00,
        ST_REF  = 2'b01,
        ST_SR   = 2'b10,
        ST_XS   = 2'b11
    } mode_e;
endpackage : dram_ctl_pkg
